// file: rtl/ofd_top.sv
// Functional notes
// RULE_01: Direction bit 1 writes to register field; 0 uses it as source.
// RULE_02: Width bit 1 means the operation works on 16-bit words.
// RULE_03: Width bit 0 selects byte registers, codes 100/101 high halves; the code maps codes 110/111 to high halves as well.
// RULE_04: Mode 11 makes the register/memory field a register code.
// RULE_05: Mode 00 gives zero displacement, no displacement bytes expected.
// RULE_06: Mode 01 takes one displacement byte, sign-extended to 16 bits.
// RULE_07: Mode 10 takes two displacement bytes, high above low.
// RULE_08: Selector 000 addresses base word plus source index plus disp.
// RULE_09: Selector 010 addresses base pointer plus index plus disp.
// RULE_10: Shift count is one when source bit 0, else low count byte.
// RULE_11: Repeat continues when compare bit matches the zero flag.
// RULE_12: Prefix 001 reg 110 overrides segment: extra, code, stack, data.
// RULE_13: Word register codes 000 to 110 map to the seven word registers.
// RULE_14: Above/below compare unsigned, greater/less compare signed values.
// RULE_15: Addressing byte holds mode 7:6, register 5:3, selector 2:0.
// RULE_16: Word register code 111 selects the destination index register.
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/10ps
module ofd_top (
    // Clock and reset
    input wire logic I_CLK_SYS,
    input wire logic I_RST_N,
    // Register port
    input wire logic [7:0] I_REG_ADDR,
    input wire logic [15:0] I_REG_WDATA,
    input wire logic I_REG_WR,
    input wire logic I_REG_RD,
    output logic [15:0] O_REG_RDATA,
    // Instruction from fetch queue
    input wire logic I_INSTR_VALID,
    input wire ofd_pkg::ofd_instr_t I_INSTR,
    input wire logic I_PREFIX_VALID,
    input wire logic [7:0] I_PREFIX_BYTE,
    input wire logic I_REP_VALID,
    input wire logic [7:0] I_REP_BYTE,
    input wire logic [15:0] I_MEM_DATA,
    // Decoded operand information
    output logic O_DEC_VALID,
    output ofd_pkg::ofd_dec_t O_DEC
);
    ofd_pkg::ofd_regs_t regs_r;
    logic zero_flag_r;
    logic seg_ovr_r;
    ofd_pkg::ofd_seg_t seg_r;
    logic rep_z_r;
    logic dec_valid_r;
    ofd_pkg::ofd_dec_t dec_r;
    ofd_pkg::ofd_dec_t dec_nxt;
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;
    logic [1:0] mode;
    logic [2:0] reg_code;
    logic [2:0] rm_code;
    logic word_op;
    logic rm_is_reg;
    logic [15:0] reg_val;
    logic [15:0] rm_reg_val;
    logic [15:0] rm_val;
    logic [1:0] disp_bytes;
    logic [15:0] disp;
    logic [15:0] ea;
    logic [15:0] cmp_a_u;
    logic [15:0] cmp_b_u;
    logic signed [15:0] cmp_a_s;
    logic signed [15:0] cmp_b_s;
    logic pfx_hit;
    logic [2:0] wr_idx;
    logic wr_reg_hit;

    // Field extraction from the addressing byte
    assign mode = I_INSTR.modrm[ofd_pkg::MODE_MSB:ofd_pkg::MODE_LSB];
    assign reg_code = I_INSTR.modrm[ofd_pkg::REG_MSB:ofd_pkg::REG_LSB];
    assign rm_code = I_INSTR.modrm[ofd_pkg::RM_MSB:ofd_pkg::RM_LSB];
    assign word_op = I_INSTR.opcode[ofd_pkg::WIDTH_BIT]; // [RULE_02]
    assign rm_is_reg = (mode == ofd_pkg::MODE_REG); // [RULE_04]

    // Segment override prefix recognition
    assign pfx_hit = I_PREFIX_VALID &&
        (I_PREFIX_BYTE[7:ofd_pkg::PFX_TOP_LSB] == ofd_pkg::PFX_TOP) &&
        (I_PREFIX_BYTE[2:0] == ofd_pkg::PFX_LOW); // [RULE_12]

    // Register port word decode
    assign wr_idx = I_REG_ADDR[4:ofd_pkg::OFS_IDX_LSB];
    assign wr_reg_hit = I_REG_WR && (I_REG_ADDR[1:0] == 2'h0) &&
        (I_REG_ADDR <= ofd_pkg::OFS_REG_LAST);

    // Register field operand
    ofd_reg_map u_reg_map (
        .i_code(reg_code),
        .i_word(word_op),
        .i_regs(regs_r),
        .o_value(reg_val)
    );

    // Register/memory field operand when it names a register
    ofd_reg_map u_rm_map (
        .i_code(rm_code),
        .i_word(word_op),
        .i_regs(regs_r),
        .o_value(rm_reg_val)
    );

    // Displacement and effective address
    ofd_ea_calc u_ea_calc (
        .i_mode(mode),
        .i_rm(rm_code),
        .i_disp_lo(I_INSTR.disp_lo),
        .i_disp_hi(I_INSTR.disp_hi),
        .i_regs(regs_r),
        .o_disp_bytes(disp_bytes),
        .o_disp(disp),
        .o_ea(ea)
    );

    // Word register file written over the register port
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_word_reg
            always_ff @(posedge I_CLK_SYS) begin
                if (!I_RST_N) begin
                    regs_r[gi] <= ofd_pkg::RST_WORD;
                end else if (wr_reg_hit && (wr_idx == 3'(gi))) begin
                    regs_r[gi] <= I_REG_WDATA;
                end
            end
        end
    endgenerate

    // Zero flag written over the register port
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            zero_flag_r <= 1'b0;
        end else if (I_REG_WR && (I_REG_ADDR == ofd_pkg::OFS_FLAGS)) begin
            zero_flag_r <= I_REG_WDATA[ofd_pkg::ZERO_FLAG_BIT];
        end
    end

    // Pending segment override, used by the next instruction
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            seg_ovr_r <= 1'b0;
            seg_r <= ofd_pkg::SEG_DATA;
        end else if (pfx_hit) begin
            seg_ovr_r <= 1'b1;
            seg_r <= ofd_pkg::ofd_seg_t'(
                I_PREFIX_BYTE[ofd_pkg::SEG_MSB:ofd_pkg::SEG_LSB]); // [RULE_12]
        end else if (I_INSTR_VALID) begin
            seg_ovr_r <= 1'b0;
        end
    end

    // Pending repeat prefix compare bit
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            rep_z_r <= 1'b0;
        end else if (I_REP_VALID) begin
            rep_z_r <= I_REP_BYTE[ofd_pkg::STR_CMP_BIT];
        end
    end

    // Operand compare: unsigned on zero-extended, signed on sign-extended
    always_comb begin
        if (rm_is_reg) begin
            rm_val = rm_reg_val;
        end else if (word_op) begin
            rm_val = I_MEM_DATA;
        end else begin
            rm_val = {8'h00, I_MEM_DATA[7:0]}; // [RULE_03]
        end
        if (word_op) begin
            cmp_a_u = reg_val;
            cmp_b_u = rm_val;
        end else begin
            cmp_a_u = {8'h00, reg_val[7:0]};
            cmp_b_u = {8'h00, rm_val[7:0]};
        end
        if (word_op) begin
            cmp_a_s = reg_val;
            cmp_b_s = rm_val;
        end else begin
            cmp_a_s = {{8{reg_val[7]}}, reg_val[7:0]};
            cmp_b_s = {{8{rm_val[7]}}, rm_val[7:0]};
        end
    end

    // Decode result assembly
    always_comb begin
        dec_nxt = dec_r;
        dec_nxt.to_reg = I_INSTR.opcode[ofd_pkg::DIR_BIT]; // [RULE_01]
        dec_nxt.word_op = word_op; // [RULE_02]
        dec_nxt.rm_is_reg = rm_is_reg; // [RULE_04]
        dec_nxt.disp_bytes = rm_is_reg ? ofd_pkg::DISP_NONE : disp_bytes;
        dec_nxt.disp = rm_is_reg ? ofd_pkg::RST_WORD : disp;
        dec_nxt.ea = rm_is_reg ? ofd_pkg::RST_WORD : ea; // [RULE_04]
        dec_nxt.reg_code = reg_code; // [RULE_15]
        dec_nxt.reg_value = reg_val; // [RULE_01]
        dec_nxt.rm_value = rm_val;
        dec_nxt.seg_ovr = seg_ovr_r;
        dec_nxt.seg = seg_r;
        if (I_INSTR.opcode[ofd_pkg::SHIFT_SRC_BIT]) begin
            dec_nxt.shift_count = regs_r[ofd_pkg::REG_COUNT][7:0]; // [RULE_10]
        end else begin
            dec_nxt.shift_count = ofd_pkg::SHIFT_ONE; // [RULE_10]
        end
        dec_nxt.rep_continue = (rep_z_r == zero_flag_r); // [RULE_11]
        dec_nxt.above = (cmp_a_u > cmp_b_u); // [RULE_14]
        dec_nxt.below = (cmp_a_u < cmp_b_u); // [RULE_14]
        dec_nxt.greater = (cmp_a_s > cmp_b_s); // [RULE_14]
        dec_nxt.less = (cmp_a_s < cmp_b_s); // [RULE_14]
        dec_nxt.equal = (cmp_a_u == cmp_b_u);
    end

    // Decode output register, held until the next instruction
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            dec_r <= '0;
            dec_valid_r <= 1'b0;
        end else begin
            dec_valid_r <= I_INSTR_VALID;
            if (I_INSTR_VALID) begin
                dec_r <= dec_nxt;
            end
        end
    end

    // Read data mux
    always_comb begin
        rdata_nxt = ofd_pkg::RST_WORD;
        if (I_REG_ADDR[1:0] == 2'h0 &&
            I_REG_ADDR <= ofd_pkg::OFS_REG_LAST) begin
            rdata_nxt = regs_r[wr_idx];
        end else if (I_REG_ADDR == ofd_pkg::OFS_FLAGS) begin
            rdata_nxt = {15'h0000, zero_flag_r};
        end else if (I_REG_ADDR == ofd_pkg::OFS_STATUS) begin
            rdata_nxt = {5'h00, dec_r.above, dec_r.below, dec_r.greater,
                dec_r.less, dec_r.equal, dec_r.seg, dec_r.seg_ovr,
                dec_r.disp_bytes, dec_r.rm_is_reg};
        end
    end

    // Read data stands only in the cycle after the read strobe
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            rdata_r <= ofd_pkg::RST_WORD;
        end else if (I_REG_RD) begin
            rdata_r <= rdata_nxt;
        end else begin
            rdata_r <= ofd_pkg::RST_WORD;
        end
    end

    // Outputs straight from flip-flops
    assign O_REG_RDATA = rdata_r;
    assign O_DEC_VALID = dec_valid_r;
    assign O_DEC = dec_r;
endmodule : ofd_top

// file: rtl/ofd_pkg.sv
package ofd_pkg;
    // Addressing byte field positions
    localparam int MODE_MSB = 7;
    localparam int MODE_LSB = 6;
    localparam int REG_MSB = 5;
    localparam int REG_LSB = 3;
    localparam int RM_MSB = 2;
    localparam int RM_LSB = 0;
    // Opcode bit positions
    localparam int DIR_BIT = 1;
    localparam int WIDTH_BIT = 0;
    localparam int SHIFT_SRC_BIT = 1;
    localparam int STR_CMP_BIT = 0;
    localparam int BYTE_SEL_BIT = 2;
    // Addressing modes
    localparam logic [1:0] MODE_NO_DISP = 2'h0;
    localparam logic [1:0] MODE_DISP8 = 2'h1;
    localparam logic [1:0] MODE_DISP16 = 2'h2;
    localparam logic [1:0] MODE_REG = 2'h3;
    // Displacement byte counts
    localparam logic [1:0] DISP_NONE = 2'h0;
    localparam logic [1:0] DISP_ONE = 2'h1;
    localparam logic [1:0] DISP_TWO = 2'h2;
    // Word register codes
    localparam logic [2:0] REG_ACCUM = 3'h0;
    localparam logic [2:0] REG_COUNT = 3'h1;
    localparam logic [2:0] REG_DATA = 3'h2;
    localparam logic [2:0] REG_BASE = 3'h3;
    localparam logic [2:0] REG_STACK_PTR = 3'h4;
    localparam logic [2:0] REG_BASE_PTR = 3'h5;
    localparam logic [2:0] REG_SRC_IDX = 3'h6;
    localparam logic [2:0] REG_DST_IDX = 3'h7;
    // Memory selector codes
    localparam logic [2:0] RM_BASE_SRC = 3'h0;
    localparam logic [2:0] RM_BASE_DST = 3'h1;
    localparam logic [2:0] RM_BPTR_SRC = 3'h2;
    localparam logic [2:0] RM_BPTR_DST = 3'h3;
    localparam logic [2:0] RM_SRC = 3'h4;
    localparam logic [2:0] RM_DST = 3'h5;
    localparam logic [2:0] RM_BPTR = 3'h6;
    localparam logic [2:0] RM_BASE = 3'h7;
    // Segment override prefix pattern
    localparam logic [2:0] PFX_TOP = 3'h1;
    localparam logic [2:0] PFX_LOW = 3'h6;
    localparam int PFX_TOP_LSB = 5;
    localparam int SEG_MSB = 4;
    localparam int SEG_LSB = 3;
    // Register port map
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_REG_BASE = 8'h00;
    localparam logic [7:0] OFS_REG_LAST = 8'h1c;
    localparam logic [7:0] OFS_FLAGS = 8'h20;
    localparam logic [7:0] OFS_STATUS = 8'h24;
    localparam int OFS_IDX_LSB = 2;
    localparam int ZERO_FLAG_BIT = 0;
    // Reset values and constants
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [7:0] SHIFT_ONE = 8'h01;

    typedef enum logic [1:0] {
        SEG_EXTRA,
        SEG_CODE,
        SEG_STACK,
        SEG_DATA
    } ofd_seg_t;

    typedef logic [7:0][15:0] ofd_regs_t;

    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] modrm;
        logic [7:0] disp_lo;
        logic [7:0] disp_hi;
    } ofd_instr_t;

    typedef struct packed {
        logic to_reg;
        logic word_op;
        logic rm_is_reg;
        logic [1:0] disp_bytes;
        logic [15:0] disp;
        logic [15:0] ea;
        logic [2:0] reg_code;
        logic [15:0] reg_value;
        logic [15:0] rm_value;
        logic seg_ovr;
        ofd_seg_t seg;
        logic [7:0] shift_count;
        logic rep_continue;
        logic above;
        logic below;
        logic greater;
        logic less;
        logic equal;
    } ofd_dec_t;
endpackage : ofd_pkg

// file: rtl/ofd_reg_map.sv
`timescale 1ns/10ps
module ofd_reg_map (
    // Register code and width
    input wire logic [2:0] i_code,
    input wire logic i_word,
    // Register contents
    input wire ofd_pkg::ofd_regs_t i_regs,
    // Selected operand value
    output logic [15:0] o_value
);
    logic [1:0] byte_idx;

    // Word code picks a full register, byte code a half
    always_comb begin
        byte_idx = i_code[1:0];
        if (i_word) begin
            o_value = i_regs[i_code]; // [RULE_02] [RULE_13] [RULE_16]
        end else if (i_code[ofd_pkg::BYTE_SEL_BIT]) begin
            o_value = {8'h00, i_regs[{1'b0, byte_idx}][15:8]}; // [RULE_03]
        end else begin
            o_value = {8'h00, i_regs[{1'b0, byte_idx}][7:0]}; // [RULE_03]
        end
    end
endmodule : ofd_reg_map

// file: rtl/ofd_ea_calc.sv
`timescale 1ns/10ps
module ofd_ea_calc (
    // Addressing fields
    input wire logic [1:0] i_mode,
    input wire logic [2:0] i_rm,
    input wire logic [7:0] i_disp_lo,
    input wire logic [7:0] i_disp_hi,
    // Register contents
    input wire ofd_pkg::ofd_regs_t i_regs,
    // Decoded displacement and address
    output logic [1:0] o_disp_bytes,
    output logic [15:0] o_disp,
    output logic [15:0] o_ea
);
    logic [15:0] base_v;
    logic [15:0] idx_v;

    // Displacement length and value per mode
    always_comb begin
        case (i_mode)
            ofd_pkg::MODE_DISP8: begin
                o_disp_bytes = ofd_pkg::DISP_ONE;
                o_disp = {{8{i_disp_lo[7]}}, i_disp_lo}; // [RULE_06]
            end
            ofd_pkg::MODE_DISP16: begin
                o_disp_bytes = ofd_pkg::DISP_TWO;
                o_disp = {i_disp_hi, i_disp_lo}; // [RULE_07]
            end
            default: begin
                o_disp_bytes = ofd_pkg::DISP_NONE; // [RULE_05]
                o_disp = ofd_pkg::RST_WORD;
            end
        endcase
    end

    // Base and index selection per memory selector
    always_comb begin
        base_v = ofd_pkg::RST_WORD;
        idx_v = ofd_pkg::RST_WORD;
        case (i_rm)
            ofd_pkg::RM_BASE_SRC: begin
                base_v = i_regs[ofd_pkg::REG_BASE]; // [RULE_08]
                idx_v = i_regs[ofd_pkg::REG_SRC_IDX];
            end
            ofd_pkg::RM_BASE_DST: begin
                base_v = i_regs[ofd_pkg::REG_BASE];
                idx_v = i_regs[ofd_pkg::REG_DST_IDX];
            end
            ofd_pkg::RM_BPTR_SRC: begin
                base_v = i_regs[ofd_pkg::REG_BASE_PTR]; // [RULE_09]
                idx_v = i_regs[ofd_pkg::REG_SRC_IDX];
            end
            ofd_pkg::RM_BPTR_DST: begin
                base_v = i_regs[ofd_pkg::REG_BASE_PTR];
                idx_v = i_regs[ofd_pkg::REG_DST_IDX];
            end
            ofd_pkg::RM_SRC: idx_v = i_regs[ofd_pkg::REG_SRC_IDX];
            ofd_pkg::RM_DST: idx_v = i_regs[ofd_pkg::REG_DST_IDX];
            ofd_pkg::RM_BPTR: base_v = i_regs[ofd_pkg::REG_BASE_PTR];
            default: base_v = i_regs[ofd_pkg::REG_BASE];
        endcase
        o_ea = 16'(base_v + idx_v + o_disp); // [RULE_08] [RULE_09]
    end
endmodule : ofd_ea_calc

// file: verif/ofd_properties.sv
`timescale 1ns/10ps
module ofd_properties (
    // Clock and reset
    input wire logic I_CLK_SYS,
    input wire logic I_RST_N,
    // Watched ports
    input wire logic I_INSTR_VALID,
    input wire ofd_pkg::ofd_instr_t I_INSTR,
    input wire logic O_DEC_VALID,
    input wire ofd_pkg::ofd_dec_t O_DEC
);
    logic [1:0] mode;
    logic take;

    // Addressing mode of the offered instruction
    assign mode = I_INSTR.modrm[7:6];
    assign take = I_INSTR_VALID;

    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RST_N);

    // Result pulse one cycle after each instruction
    property p_pulse;
        take |=> O_DEC_VALID;
    endproperty
    a_pulse: assert property (p_pulse) else $error("no pulse");
    // Operand fields follow the opcode bits and the addressing mode
    property p_dir;
        take |=> O_DEC.to_reg == $past(I_INSTR.opcode[1]);
    endproperty
    a_dir: assert property (p_dir) else $error("dir");
    property p_width;
        take |=> O_DEC.word_op == $past(I_INSTR.opcode[0]);
    endproperty
    a_width: assert property (p_width) else $error("width");
    property p_regmode;
        take |=> O_DEC.rm_is_reg == ($past(mode) == 2'h3);
    endproperty
    a_regmode: assert property (p_regmode) else $error("rm");
    // Displacement forms for modes 00, 01 and 10, then the shift count of one
    property p_nodisp;
        take && mode == 2'h0 |=> O_DEC.disp_bytes == 2'h0 &&
            O_DEC.disp == 16'h0;
    endproperty
    a_nodisp: assert property (p_nodisp) else $error("disp0");
    property p_disp8;
        take && mode == 2'h1 |=> O_DEC.disp_bytes == 2'h1 &&
            O_DEC.disp ==
            {{8{$past(I_INSTR.disp_lo[7])}}, $past(I_INSTR.disp_lo)};
    endproperty
    a_disp8: assert property (p_disp8) else $error("disp8");
    property p_disp16;
        take && mode == 2'h2 |=> O_DEC.disp_bytes == 2'h2 &&
            O_DEC.disp == {$past(I_INSTR.disp_hi), $past(I_INSTR.disp_lo)};
    endproperty
    a_disp16: assert property (p_disp16) else $error("disp16");
    property p_shift1;
        take && !I_INSTR.opcode[1] |=> O_DEC.shift_count == 8'h01;
    endproperty
    a_shift1: assert property (p_shift1) else $error("shift");
endmodule : ofd_properties

bind ofd_top ofd_properties i_props (
    .I_CLK_SYS(I_CLK_SYS),
    .I_RST_N(I_RST_N),
    .I_INSTR_VALID(I_INSTR_VALID),
    .I_INSTR(I_INSTR),
    .O_DEC_VALID(O_DEC_VALID),
    .O_DEC(O_DEC)
);

// file: verif/ofd_fetch_model.sv
`timescale 1ns/10ps
module ofd_fetch_model (
    // Clock
    input wire logic i_clk,
    // Requests from the bench
    input wire logic i_go,
    input wire ofd_pkg::ofd_instr_t i_instr,
    input wire logic i_pfx_go,
    input wire logic [7:0] i_pfx,
    input wire logic i_rep_go,
    input wire logic [7:0] i_rep,
    input wire logic [15:0] i_mem,
    // Towards the decoder
    output logic o_instr_valid = 1'b0,
    output ofd_pkg::ofd_instr_t o_instr,
    output logic o_pfx_valid = 1'b0,
    output logic [7:0] o_pfx,
    output logic o_rep_valid = 1'b0,
    output logic [7:0] o_rep,
    output logic [15:0] o_mem
);
    // One-cycle offers; idle buses carry scrambled bytes
    always @(posedge i_clk) begin
        o_instr_valid <= i_go;
        o_instr <= i_go ? i_instr : ~i_instr;
        o_pfx_valid <= i_pfx_go;
        o_pfx <= i_pfx_go ? i_pfx : ~i_pfx;
        o_rep_valid <= i_rep_go;
        o_rep <= i_rep_go ? i_rep : ~i_rep;
        o_mem <= i_go ? i_mem : ~i_mem;
    end
endmodule : ofd_fetch_model

// file: verif/test_operand_field_decoder.sv
`timescale 1ns/10ps
module test_operand_field_decoder;
    logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, rd_seen = 1'b0;
    logic go = 1'b0, pgo = 1'b0, rgo = 1'b0, pend = 1'b0, zb = 1'b0;
    logic zf = 1'b0, dvalid, f_iv, f_pv, f_rv;
    logic [7:0] addr = 8'h00, pb = 8'h00, rb = 8'h00, f_pb, f_rb;
    logic [15:0] wdata = 16'h0000, mem = 16'h0000, rdata, f_mem;
    logic [1:0] pseg = 2'h3;
    logic [15:0] rg [8] = '{default: 16'h0000};
    ofd_pkg::ofd_instr_t ins = '0, f_ins, n;
    ofd_pkg::ofd_dec_t dec, ld;
    ofd_pkg::ofd_dec_t decq [$];
    logic [15:0] rdq [$];
    int bad_count = 0, comparisons = 0, seed = 29748, r;

    ofd_fetch_model i_fetch (.i_clk(clk), .i_go(go), .i_instr(ins),
        .i_pfx_go(pgo), .i_pfx(pb), .i_rep_go(rgo), .i_rep(rb), .i_mem(mem),
        .o_instr_valid(f_iv), .o_instr(f_ins), .o_pfx_valid(f_pv),
        .o_pfx(f_pb), .o_rep_valid(f_rv), .o_rep(f_rb), .o_mem(f_mem));
    ofd_top i_dut (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_REG_ADDR(addr),
        .I_REG_WDATA(wdata), .I_REG_WR(wr), .I_REG_RD(rd), .O_REG_RDATA(rdata),
        .I_INSTR_VALID(f_iv), .I_INSTR(f_ins), .I_PREFIX_VALID(f_pv),
        .I_PREFIX_BYTE(f_pb), .I_REP_VALID(f_rv), .I_REP_BYTE(f_rb),
        .I_MEM_DATA(f_mem), .O_DEC_VALID(dvalid), .O_DEC(dec));

    // Clock
    always #25 clk = ~clk;

    // Operand value as the decoder should select it
    function automatic logic [15:0] opnd(logic [2:0] c, logic w);
        if (w) return rg[c];
        return c[2] ? {8'h00, rg[c[1:0]][15:8]} : {8'h00, rg[c[1:0]][7:0]};
    endfunction : opnd

    // Expected decode result from current register and prefix state
    function automatic ofd_pkg::ofd_dec_t model(ofd_pkg::ofd_instr_t i,
                                                logic [15:0] m);
        ofd_pkg::ofd_dec_t d;
        logic [1:0] md;
        logic w;
        logic [15:0] a, b;
        d = '0;
        md = i.modrm[7:6];
        w = i.opcode[0];
        d.to_reg = i.opcode[1];
        d.word_op = w;
        d.rm_is_reg = md == 2'h3;
        d.reg_code = i.modrm[5:3];
        d.disp_bytes = d.rm_is_reg ? 2'h0 : md;
        d.disp = md == 2'h1 ? {{8{i.disp_lo[7]}}, i.disp_lo} :
                 md == 2'h2 ? {i.disp_hi, i.disp_lo} : 16'h0000;
        d.ea = d.rm_is_reg ? 16'h0000 :
            (i.modrm[1] ? rg[5] : rg[3]) + rg[6] + d.disp;
        a = opnd(i.modrm[5:3], w);
        b = d.rm_is_reg ? opnd(i.modrm[2:0], w) : (w ? m : {8'h00, m[7:0]});
        d.reg_value = a;
        d.rm_value = b;
        d.seg_ovr = pend;
        d.seg = ofd_pkg::ofd_seg_t'(pseg);
        d.shift_count = i.opcode[1] ? rg[1][7:0] : 8'h01;
        d.rep_continue = zb == zf;
        d.above = a > b;
        d.below = a < b;
        d.equal = a == b;
        d.greater = w ? $signed(a) > $signed(b) :
            $signed(a[7:0]) > $signed(b[7:0]);
        d.less = w ? $signed(a) < $signed(b) :
            $signed(a[7:0]) < $signed(b[7:0]);
        return d;
    endfunction : model

    task automatic check(string what, logic [127:0] exp, logic [127:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic reg_op(logic w, logic [7:0] a, logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        go <= 1'b0;
        pgo <= 1'b0;
        rgo <= 1'b0;
        if (!w) rdq.push_back(d);
        if (w && a[1:0] == 2'h0 && a < 8'h20) rg[a[4:2]] = d;
        if (w && a == 8'h20) zf = d[0];
    endtask : reg_op

    task automatic send(logic g, ofd_pkg::ofd_instr_t i, logic p,
                        logic [1:0] s, logic q, logic z);
        logic [15:0] m;
        m = 16'($random(seed));
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        go <= g;
        ins <= i;
        pgo <= p;
        pb <= {3'h1, s, 3'h6};
        rgo <= q;
        rb <= {7'h5a, z};
        mem <= m;
        if (g) ld = model(i, m);
        if (g) decq.push_back(ld);
        if (q) zb = z;
        if (p) pseg = s;
        if (p || g) pend = p;
    endtask : send

    // Result watcher, oldest note first
    always @(posedge clk) rd_seen <= rd;
    always @(negedge clk) begin
        if (rd_seen === 1'b1) check("read", rdq.pop_front(), rdata);
        else check("idle read", 16'h0000, rdata);
        if (dvalid === 1'b1 && decq.size() == 0) check("extra", 0, 1);
        else if (dvalid === 1'b1)
            check("dec", decq.pop_front(), dec);
    end

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish

    // Hang guard
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        tally_and_finish;
    end

    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 14; i++) reg_op(0, 8'(i * 4), 16'h0000);
        reg_op(1, 8'h24, 16'hffff);
        reg_op(1, 8'h0d, 16'hffff);
        reg_op(1, 8'h30, 16'hffff);
        reg_op(0, 8'h24, 16'h0000);
        reg_op(0, 8'h0c, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            reg_op(1, 8'(i * 4), 16'($random(seed)));
            reg_op(0, 8'(i * 4), rg[i]);
        end
        send(0, '0, 1, 2'h0, 0, 0);
        send(1, {8'h03, 8'h40, 8'hff, 8'h00}, 0, 2'h0, 0, 0);
        for (int s = 0; s < 5; s++)
            send(1, 32'h8b000000, s < 4, 2'(s), 0, 0);
        for (int i = 0; i < 16; i++)
            send(1, {7'h44, i[3], 2'h3, i[2:0], ~i[2:0], 16'h0}, 0, 0, 0, 0);
        for (int i = 0; i < 6; i++)
            send(1, {8'h03, 2'(i / 2), 4'h8, i[0], 1'b0,
                16'($random(seed))}, 0, 0, 0, 0);
        for (int i = 0; i < 4; i++) begin
            reg_op(1, 8'h20, 16'(i[1]));
            send(0, '0, 0, 0, 1, i[0]);
            send(1, {6'h34, i[0], i[1], 24'he10000}, 0, 0, 0, 0);
        end
        for (int i = 0; i < 300; i++) begin
            n = $random(seed);
            r = $random(seed);
            if (n.modrm[7:6] != 2'h3) n.modrm[2:0] = {1'b0, n.modrm[1], 1'b0};
            if (r[5:3] == 3'h0) send(0, n, 0, 0, 1, r[6]);
            send(1, n, r[0], r[2:1], 0, 0);
        end
        send(0, '0, 0, 0, 0, 0);
        for (int k = 0; k < 50 && decq.size() > 0; k++) @(posedge clk);
        if (decq.size() != 0) bad_count++;
        reg_op(0, 8'h24, {5'h00, ld.above, ld.below, ld.greater, ld.less,
            ld.equal, ld.seg, ld.seg_ovr, ld.disp_bytes, ld.rm_is_reg});
        send(0, '0, 0, 0, 0, 0);
        repeat (2) @(posedge clk);
        if (rdq.size() != 0) bad_count++;
        tally_and_finish;
    end
endmodule : test_operand_field_decoder
